//--- core/dsw_pkg.sv
package dsw_pkg;
   // Register offsets on the AHB-Lite side
   localparam logic [7:0] OFS_CTRL = 8'h00;
   localparam logic [7:0] OFS_STAT = 8'h04;
   localparam logic [7:0] OFS_DIV = 8'h08;
   localparam logic [7:0] OFS_TIMA = 8'h0c;
   localparam logic [7:0] OFS_TIMB = 8'h10;
   localparam logic [7:0] OFS_TIMC = 8'h14;
   localparam logic [7:0] OFS_MRA = 8'h18;
   localparam logic [7:0] OFS_MRB = 8'h1c;
   // Control and status bits
   localparam int CTRL_GO = 0;
   localparam int CTRL_OFF = 1;
   localparam int CTRL_ZQ = 2;
   localparam int STAT_BUSY = 0;
   localparam int STAT_DLL_OFF = 1;
   localparam int STAT_DONE = 2;
   // Timing fields in link clock cycles, then mode register value fields
   localparam int TA_MOD = 0;
   localparam int TA_MRD = 8;
   localparam int TA_CKSRE = 16;
   localparam int TA_CKSRX = 24;
   localparam int TB_XS = 0;
   localparam int TB_ZQ = 16;
   localparam int MRA_MR0 = 0;
   localparam int MRA_MR1 = 16;
   // Mode register bits and bank codes
   localparam int MR1_DLL_DIS = 0;
   localparam int MR0_DLL_RST = 8;
   localparam logic [2:0] BA_MR0 = 3'h0;
   localparam logic [2:0] BA_MR1 = 3'h1;
   localparam logic [2:0] BA_MR2 = 3'h2;
   localparam logic [13:0] ADDR_AP = 14'h0400;
   // Command codes as {ras_b, cas_b, we_b}
   localparam logic [2:0] CMD_MRS = 3'h0;
   localparam logic [2:0] CMD_REF = 3'h1;
   localparam logic [2:0] CMD_PRE = 3'h2;
   localparam logic [2:0] CMD_ZQ = 3'h6;
   localparam logic [2:0] CMD_NOP = 3'h7;
   // Reset values
   localparam logic [7:0] DIV_RST = 8'h01;
   localparam logic [31:0] TIMA_RST = 32'h0505040c;
   localparam logic [31:0] TIMB_RST = 32'h01000080;
   localparam logic [15:0] TIMC_RST = 16'h0200;

   typedef struct packed {
      logic cke;
      logic cs_b;
      logic [2:0] cmd;
      logic [2:0] ba;
      logic [13:0] addr;
      logic odt;
   } ddr_pins_t;

   localparam ddr_pins_t PINS_RST = '{cke: 1'b1, cs_b: 1'b1,
      cmd: CMD_NOP, ba: 3'h0, addr: 14'h0000, odt: 1'b0};

   typedef enum logic [9:0] {
      st_idle = 10'h001,
      st_mrs1 = 10'h002,
      st_sre = 10'h004,
      st_chg = 10'h008,
      st_srx = 10'h010,
      st_mrs0 = 10'h020,
      st_mrs2 = 10'h040,
      st_zq = 10'h080,
      st_wait = 10'h100,
      st_fin = 10'h200
   } seq_state_t;

   function automatic logic is_mrs(input ddr_pins_t p);
      return !p.cs_b && (p.cmd == CMD_MRS);
   endfunction
endpackage

//--- core/ddr_dll_switch_ctrl.sv
// Chosen here: the register offsets and the AHB-Lite interface to the registers.
`timescale 1ns/100ps
module ddr_dll_switch_ctrl (
   input wire logic ref_clk_i, // System clock, 50 MHz
   input wire logic rst_b_i, // Async reset, active low
   input wire logic hsel_i, // AHB select
   input wire logic [31:0] haddr_i, // AHB address
   input wire logic [1:0] htrans_i, // AHB transfer type
   input wire logic hwrite_i, // AHB write
   input wire logic [2:0] hsize_i, // AHB size, word only
   input wire logic [31:0] hwdata_i, // AHB write data
   input wire logic hready_i, // AHB bus ready
   output logic [31:0] hrdata_o, // AHB read data
   output logic hreadyout_o, // AHB slave ready
   output logic hresp_o, // AHB response, always OKAY
   output logic ck_o, // Memory clock
   output logic ck_c_o, // Memory clock complement
   output logic cke_o, // Clock enable
   output logic cs_b_o, // Chip select, active low
   output logic ras_b_o, // Row strobe, active low
   output logic cas_b_o, // Column strobe, active low
   output logic we_b_o, // Write enable, active low
   output logic [2:0] ba_o, // Bank address
   output logic [13:0] addr_o, // Address
   output logic odt_o // Termination control
);

   typedef struct packed {
      dsw_pkg::seq_state_t st;
      dsw_pkg::seq_state_t ret;
      logic [15:0] cnt;
      logic [15:0] dllk;
      logic [7:0] pc;
      logic [7:0] div;
      logic ck;
      logic ck_c;
      dsw_pkg::ddr_pins_t pins;
      logic go;
      logic to_off;
      logic zq;
      logic dll_off;
      logic done;
      logic cfg_off;
      logic cfg_zq;
      logic [7:0] new_div;
      logic [31:0] tima;
      logic [31:0] timb;
      logic [15:0] timc;
      logic [31:0] mra;
      logic [15:0] mrb;
      logic wr;
      logic rd;
      logic [7:0] ba;
      logic [31:0] rdata;
      logic hready;
   } st_t;

   localparam st_t ST_RST = '{st: dsw_pkg::st_idle,
      ret: dsw_pkg::st_idle, div: dsw_pkg::DIV_RST,
      new_div: dsw_pkg::DIV_RST, ck_c: 1'b1,
      pins: dsw_pkg::PINS_RST, tima: dsw_pkg::TIMA_RST,
      timb: dsw_pkg::TIMB_RST, timc: dsw_pkg::TIMC_RST,
      hready: 1'b1, default: '0};

   st_t q;
   st_t n;
   logic rise;
   logic fall;

   function automatic st_t to_wait(input st_t s, input logic [15:0] c,
                                   input dsw_pkg::seq_state_t r);
      st_t t;
      t = s;
      t.cnt = c;
      t.ret = r;
      t.st = dsw_pkg::st_wait;
      return t;
   endfunction

   function automatic dsw_pkg::ddr_pins_t mk_cmd(input logic [2:0] c,
      input logic [2:0] b, input logic [13:0] a, input logic k);
      mk_cmd = '{cke: k, cs_b: 1'b0, cmd: c, ba: b, addr: a, odt: 1'b0};
   endfunction

   // Commands change on the falling link edge, so they are centred
   // on the rising edge at which the memory registers them.
   assign rise = (q.pc == 8'h00) && !q.ck;
   assign fall = (q.pc == 8'h00) && q.ck;

   always_comb begin
      logic [15:0] tmod;
      logic [15:0] tmrd;
      tmod = {8'h00, q.tima[dsw_pkg::TA_MOD +: 8]};
      tmrd = {8'h00, q.tima[dsw_pkg::TA_MRD +: 8]};
      n = q;
      // Link clock divider, half period is div plus one
      if (q.pc == 8'h00) begin
         n.ck = !q.ck;
         n.pc = q.div;
      end else begin
         n.pc = q.pc - 8'h01;
      end
      n.ck_c = !n.ck;
      if (rise && (q.cnt != 16'h0000)) begin
         n.cnt = q.cnt - 16'h0001;
      end
      if (rise && (q.dllk != 16'h0000)) begin
         n.dllk = q.dllk - 16'h0001;
      end

      // Register bus, reads take one wait state
      n.wr = 1'b0;
      n.hready = 1'b1;
      if (q.wr) begin
         case (q.ba)
            dsw_pkg::OFS_CTRL: begin
               n.cfg_off = hwdata_i[dsw_pkg::CTRL_OFF];
               n.cfg_zq = hwdata_i[dsw_pkg::CTRL_ZQ];
               if (hwdata_i[dsw_pkg::CTRL_GO] &&
                   (q.st == dsw_pkg::st_idle)) begin
                  n.go = 1'b1;
               end
            end
            dsw_pkg::OFS_DIV: n.new_div = hwdata_i[7:0];
            dsw_pkg::OFS_TIMA: n.tima = hwdata_i;
            dsw_pkg::OFS_TIMB: n.timb = hwdata_i;
            dsw_pkg::OFS_TIMC: n.timc = hwdata_i[15:0];
            dsw_pkg::OFS_MRA: n.mra = hwdata_i;
            dsw_pkg::OFS_MRB: n.mrb = hwdata_i[15:0];
            default: ;
         endcase
      end
      if (q.rd) begin
         n.rd = 1'b0;
         case (q.ba)
            dsw_pkg::OFS_CTRL:
               n.rdata = {29'h0, q.cfg_zq, q.cfg_off, q.go};
            dsw_pkg::OFS_STAT:
               n.rdata = {29'h0, q.done, q.dll_off,
                          q.st != dsw_pkg::st_idle};
            dsw_pkg::OFS_DIV: n.rdata = {24'h0, q.new_div};
            dsw_pkg::OFS_TIMA: n.rdata = q.tima;
            dsw_pkg::OFS_TIMB: n.rdata = q.timb;
            dsw_pkg::OFS_TIMC: n.rdata = {16'h0, q.timc};
            dsw_pkg::OFS_MRA: n.rdata = q.mra;
            dsw_pkg::OFS_MRB: n.rdata = {16'h0, q.mrb};
            default: n.rdata = 32'h0;
         endcase
      end else if (hsel_i && htrans_i[1] && hready_i) begin
         n.ba = {haddr_i[7:2], 2'b00};
         n.wr = hwrite_i;
         n.rd = !hwrite_i;
         n.hready = hwrite_i;
      end

      // Sequencer, steps only on the falling link edge
      if (fall) begin
         n.pins.cs_b = 1'b1;
         n.pins.cmd = dsw_pkg::CMD_NOP;
         n.pins.odt = 1'b0;
         case (q.st)
            dsw_pkg::st_idle: begin
               if (q.go) begin
                  n.go = 1'b0;
                  n.done = 1'b0;
                  n.to_off = q.cfg_off;
                  n.zq = q.cfg_zq;
                  // Precharge all so the sequence starts idle
                  n.pins = mk_cmd(dsw_pkg::CMD_PRE, 3'h0,
                                  dsw_pkg::ADDR_AP, 1'b1);
                  n = to_wait(n, tmrd, q.cfg_off ?
                     dsw_pkg::st_mrs1 : dsw_pkg::st_sre);
               end
            end
            dsw_pkg::st_mrs1: begin
               n.pins = mk_cmd(dsw_pkg::CMD_MRS, dsw_pkg::BA_MR1,
                               q.mra[dsw_pkg::MRA_MR1 +: 14], 1'b1);
               n.pins.addr[dsw_pkg::MR1_DLL_DIS] = q.to_off;
               if (q.to_off) begin
                  n = to_wait(n, tmod, dsw_pkg::st_sre);
               end else begin
                  n = to_wait(n, tmrd, dsw_pkg::st_mrs0);
               end
            end
            dsw_pkg::st_sre: begin
               n.pins = mk_cmd(dsw_pkg::CMD_REF, 3'h0, 14'h0000, 1'b0);
               n = to_wait(n, {8'h00, q.tima[dsw_pkg::TA_CKSRE +: 8]},
                           dsw_pkg::st_chg);
            end
            dsw_pkg::st_chg: begin
               // Clock may only change with CKE low
               n.div = q.new_div;
               n = to_wait(n, {8'h00, q.tima[dsw_pkg::TA_CKSRX +: 8]},
                           dsw_pkg::st_srx);
            end
            dsw_pkg::st_srx: begin
               n.pins = mk_cmd(dsw_pkg::CMD_NOP, 3'h0, 14'h0000,
                               1'b1);
               n = to_wait(n, q.timb[dsw_pkg::TB_XS +: 16], q.to_off ?
                  dsw_pkg::st_mrs0 : dsw_pkg::st_mrs1);
            end
            dsw_pkg::st_mrs0: begin
               n.pins = mk_cmd(dsw_pkg::CMD_MRS, dsw_pkg::BA_MR0,
                               q.mra[dsw_pkg::MRA_MR0 +: 14], 1'b1);
               n.pins.addr[dsw_pkg::MR0_DLL_RST] = !q.to_off;
               if (q.to_off) begin
                  n = to_wait(n, tmod, dsw_pkg::st_mrs2);
               end else begin
                  n.dllk = q.timc;
                  n = to_wait(n, tmrd, dsw_pkg::st_mrs2);
               end
            end
            dsw_pkg::st_mrs2: begin
               n.pins = mk_cmd(dsw_pkg::CMD_MRS, dsw_pkg::BA_MR2,
                               q.mrb[13:0], 1'b1);
               n = to_wait(n, tmod, q.zq ?
                  dsw_pkg::st_zq : dsw_pkg::st_fin);
            end
            dsw_pkg::st_zq: begin
               n.pins = mk_cmd(dsw_pkg::CMD_ZQ, 3'h0,
                               dsw_pkg::ADDR_AP, 1'b1);
               n = to_wait(n, q.timb[dsw_pkg::TB_ZQ +: 16],
                           dsw_pkg::st_fin);
            end
            dsw_pkg::st_wait: begin
               if (q.cnt == 16'h0000) begin
                  n.st = q.ret;
               end
            end
            dsw_pkg::st_fin: begin
               // Held here until the DLL has had time to lock
               if (q.dllk == 16'h0000) begin
                  n.st = dsw_pkg::st_idle;
                  n.done = 1'b1;
                  n.dll_off = q.to_off;
               end
            end
            default: n.st = dsw_pkg::st_idle;
         endcase
      end
   end

   always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         q <= ST_RST;
      end else begin
         q <= n;
      end
   end

   assign hrdata_o = q.rdata;
   assign hreadyout_o = q.hready;
   assign hresp_o = 1'b0;
   assign ck_o = q.ck;
   assign ck_c_o = q.ck_c;
   assign cke_o = q.pins.cke;
   assign cs_b_o = q.pins.cs_b;
   assign ras_b_o = q.pins.cmd[2];
   assign cas_b_o = q.pins.cmd[1];
   assign we_b_o = q.pins.cmd[0];
   assign ba_o = q.pins.ba;
   assign addr_o = q.pins.addr;
   assign odt_o = q.pins.odt;

   default clocking cb @(posedge ref_clk_i);
   endclocking
   default disable iff (!rst_b_i);

   property p_div_in_sr;
      $changed(q.div) |-> !q.pins.cke && (q.ret == dsw_pkg::st_srx);
   endproperty
   a_div_in_sr: assert property (p_div_in_sr)
      else $error("clock divider changed outside self refresh");

   property p_exit_after_srx;
      $rose(q.pins.cke) |-> $past(q.st) == dsw_pkg::st_srx;
   endproperty
   a_exit_after_srx: assert property (p_exit_after_srx)
      else $error("self refresh exit not from its wait");

   property p_mr1_off;
      dsw_pkg::is_mrs(q.pins) && (q.pins.ba == dsw_pkg::BA_MR1) &&
         q.to_off |-> q.pins.addr[dsw_pkg::MR1_DLL_DIS] && !q.pins.odt;
   endproperty
   a_mr1_off: assert property (p_mr1_off)
      else $error("DLL-off write without A0 or with ODT high");

   property p_cke_hold;
      $fell(q.pins.cke) |-> $past(q.st) == dsw_pkg::st_sre;
   endproperty
   a_cke_hold: assert property (p_cke_hold)
      else $error("CKE dropped outside self refresh entry");

   property p_odt_low;
      (q.st != dsw_pkg::st_idle) |-> !q.pins.odt;
   endproperty
   a_odt_low: assert property (p_odt_low)
      else $error("ODT high during switch");

   property p_mr1_on;
      dsw_pkg::is_mrs(q.pins) && (q.pins.ba == dsw_pkg::BA_MR1) &&
         !q.to_off |-> !q.pins.addr[dsw_pkg::MR1_DLL_DIS];
   endproperty
   a_mr1_on: assert property (p_mr1_on)
      else $error("DLL-on write with A0 set");

   property p_mr0_rst;
      // First cycle of the command only, before the lock timer moves
      dsw_pkg::is_mrs(q.pins) && (q.pins.ba == dsw_pkg::BA_MR0) &&
         !q.to_off && $past(q.pins.cs_b) |->
         q.pins.addr[dsw_pkg::MR0_DLL_RST] && (q.dllk == q.timc);
   endproperty
   a_mr0_rst: assert property (p_mr0_rst)
      else $error("DLL reset write without A8 or lock timer");

   property p_wait_holds;
      (q.st == dsw_pkg::st_wait) && (q.cnt != 16'h0000)
         |=> (q.st == dsw_pkg::st_wait) &&
         (q.pins.cs_b || $stable(q.pins));
   endproperty
   a_wait_holds: assert property (p_wait_holds)
      else $error("command issued before wait expired");

   property p_dllk_hold;
      (q.st == dsw_pkg::st_fin) && (q.dllk != 16'h0000)
         |=> q.st == dsw_pkg::st_fin;
   endproperty
   a_dllk_hold: assert property (p_dllk_hold)
      else $error("switch finished before tDLLK");

endmodule // ddr_dll_switch_ctrl

//--- test/ddr_dev_model.sv
`timescale 1ns/100ps
module ddr_dev_model (
   input wire logic ck_i, // Memory clock from controller
   input wire logic cke_i, // Clock enable
   input wire logic cs_b_i, // Chip select, active low
   input wire logic ras_b_i, // Row strobe, active low
   input wire logic cas_b_i, // Column strobe, active low
   input wire logic we_b_i, // Write enable, active low
   input wire logic [2:0] ba_i, // Bank address
   input wire logic [13:0] addr_i, // Address
   input wire logic odt_i // Termination control
);
   logic [31:0] l_c[$];
   int l_t[$];
   int ck_n = 0;
   int err_n = 0;
   int rst_n = 0;
   logic dll_dis_q = 1'b0;
   logic sr_q = 1'b0;
   logic cke_q = 1'b0;
   logic mrs, sre;
   realtime t_q = 0;
   realtime p_q = 0;
   realtime p;
   // Listen only; nothing goes back to the controller
   always @(posedge ck_i) begin
      ck_n = ck_n + 1;
      p = $realtime - t_q;
      mrs = !cs_b_i && {ras_b_i, cas_b_i, we_b_i} == dsw_pkg::CMD_MRS;
      sre = !cs_b_i && !cke_i &&
         {ras_b_i, cas_b_i, we_b_i} == dsw_pkg::CMD_REF;
      if (!cs_b_i) begin
         l_c.push_back({11'h0, cke_i, ras_b_i, cas_b_i, we_b_i, ba_i,
            addr_i});
         l_t.push_back(ck_n);
      end
      if (mrs && ba_i == dsw_pkg::BA_MR1)
         dll_dis_q = addr_i[0];
      if (mrs && ba_i == dsw_pkg::BA_MR0 && addr_i[8] && !dll_dis_q)
         rst_n++;
      if (!cke_i && !sr_q && !sre)
         err_n++;
      if (odt_i)
         err_n++;
      // Period may only move while the clock is gated off
      if (cke_i && cke_q && p_q > 0 && p != p_q)
         err_n++;
      if (sre)
         sr_q = 1'b1;
      else if (cke_i)
         sr_q = 1'b0;
      cke_q = cke_i;
      p_q = (t_q > 0) ? p : 0;
      t_q = $realtime;
   end
endmodule // ddr_dev_model

//--- test/test_ddr_dll_switch_ctrl.sv
`timescale 1ns/100ps
module test_ddr_dll_switch_ctrl;
   logic ref_clk_i = 1'b0;
   logic rst_b_i = 1'b0;
   logic hsel = 1'b0;
   logic [31:0] haddr = 32'h0;
   logic [1:0] htrans = 2'h0;
   logic hwrite = 1'b0;
   logic [31:0] hwdata = 32'h0;
   logic [31:0] hrdata;
   logic hready, hresp, ck, ck_c, cke, cs_b, ras_b, cas_b, we_b, odt;
   logic [2:0] ba;
   logic [13:0] addr;
   logic rdy_s = 1'b1;
   logic [31:0] rd_s = 32'h0;
   logic [31:0] e_w[$];
   logic [31:0] e_m[$];
   int e_g[$];
   int n_mismatch = 0;
   int tests_run = 0;
   int seed = 32'he115;
   int base = 0;
   int ck_bad = 0;
   int k;

   ddr_dll_switch_ctrl i_ddr_dll_switch_ctrl (.ref_clk_i(ref_clk_i),
      .rst_b_i(rst_b_i), .hsel_i(hsel), .haddr_i(haddr), .htrans_i(htrans),
      .hwrite_i(hwrite), .hsize_i(3'h2), .hwdata_i(hwdata),
      .hready_i(hready), .hrdata_o(hrdata), .hreadyout_o(hready),
      .hresp_o(hresp), .ck_o(ck), .ck_c_o(ck_c), .cke_o(cke),
      .cs_b_o(cs_b), .ras_b_o(ras_b), .cas_b_o(cas_b), .we_b_o(we_b),
      .ba_o(ba), .addr_o(addr), .odt_o(odt));
   ddr_dev_model i_ddr_dev_model (.ck_i(ck), .cke_i(cke), .cs_b_i(cs_b),
      .ras_b_i(ras_b), .cas_b_i(cas_b), .we_b_i(we_b), .ba_i(ba),
      .addr_i(addr), .odt_i(odt));

   always #10 ref_clk_i = ~ref_clk_i;
   // Registered outputs are settled by the falling edge
   always @(negedge ref_clk_i) begin
      rdy_s = hready;
      rd_s = hrdata;
      if (ck_c !== ~ck)
         ck_bad++;
   end

   task automatic summarize();
      $display("checks %0d mismatches %0d", tests_run, n_mismatch);
      if (n_mismatch == 0 && tests_run > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask

   task automatic chk_val(input string nm, input logic [31:0] e,
      input logic [31:0] g);
      tests_run++;
      if (g !== e) begin
         n_mismatch++;
         $display("[ERR] %s expected %h seen %h", nm, e, g);
      end
   endtask

   task automatic ahb(input logic w, input logic [7:0] a,
      input logic [31:0] wd, output logic [31:0] rd);
      @(posedge ref_clk_i);
      hsel <= 1'b1;
      htrans <= 2'h2;
      haddr <= {24'h0, a};
      hwrite <= w;
      do @(posedge ref_clk_i); while (rdy_s !== 1'b1);
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= wd;
      do @(posedge ref_clk_i); while (rdy_s !== 1'b1);
      rd = rd_s;
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] t;
      ahb(1'b1, a, d, t);
   endtask

   task automatic rdc(input string nm, input logic [7:0] a,
      input logic [31:0] e);
      logic [31:0] t;
      ahb(1'b0, a, 32'h0, t);
      chk_val(nm, e, t);
   endtask

   task automatic push(input logic [2:0] c, input logic [2:0] b,
      input logic [13:0] a, input logic [16:0] m, input int g);
      e_w.push_back({11'h0, c != dsw_pkg::CMD_REF, c, b & m[16:14],
         a & m[13:0]});
      e_m.push_back({11'h0, 4'hf, m});
      e_g.push_back(g);
   endtask

   task automatic chk_cmd(input int i);
      int gap;
      gap = 0;
      if (i > 0)
         gap = i_ddr_dev_model.l_t[base+i] - i_ddr_dev_model.l_t[base+i-1];
      chk_val("cmd", e_w[i], i_ddr_dev_model.l_c[base+i] & e_m[i]);
      // Leaving a wait costs one ck period beyond its count
      if (e_g[i] > 0)
         chk_val("gap", e_g[i] + 1, gap);
      if (e_g[i] < 0)
         chk_val("gap_min", 32'h1, 32'(gap >= -e_g[i]));
   endtask

   task automatic run_switch(input logic off, input logic zq);
      int tmod, tmrd, tsre, tsrx, txs, i, n;
      logic [13:0] m0, m1, m2;
      logic [31:0] r;
      tmod = 2 + ($random(seed) & 3);
      tmrd = 2 + ($random(seed) & 3);
      tsre = 1 + ($random(seed) & 3);
      tsrx = 2 + ($random(seed) & 3);
      txs = 3 + ($random(seed) & 7);
      m0 = 14'($random(seed));
      m1 = 14'($random(seed));
      m2 = 14'($random(seed));
      wr(dsw_pkg::OFS_TIMA, {tsrx[7:0], tsre[7:0], tmrd[7:0], tmod[7:0]});
      wr(dsw_pkg::OFS_TIMB, {16'h0005, txs[15:0]});
      wr(dsw_pkg::OFS_TIMC, 32'h00000018);
      wr(dsw_pkg::OFS_DIV, off ? 32'h3 : 32'h1);
      wr(dsw_pkg::OFS_MRA, {2'h0, m1, 2'h0, m0});
      wr(dsw_pkg::OFS_MRB, {18'h0, m2});
      e_w.delete();
      e_m.delete();
      e_g.delete();
      base = i_ddr_dev_model.l_c.size();
      push(dsw_pkg::CMD_PRE, 3'h0, dsw_pkg::ADDR_AP, 17'h00400, 0);
      if (off) begin
         push(dsw_pkg::CMD_MRS, dsw_pkg::BA_MR1, m1 | 14'h1, 17'h1ffff,
            tmrd);
         push(dsw_pkg::CMD_REF, 3'h0, 14'h0, 17'h0, tmod);
      end else
         push(dsw_pkg::CMD_REF, 3'h0, 14'h0, 17'h0, tmrd);
      push(dsw_pkg::CMD_NOP, 3'h0, 14'h0, 17'h0, -(tsre + tsrx));
      if (off) begin
         push(dsw_pkg::CMD_MRS, dsw_pkg::BA_MR0, m0 & 14'h3eff, 17'h1ffff,
            txs);
         push(dsw_pkg::CMD_MRS, dsw_pkg::BA_MR2, m2, 17'h1ffff, tmod);
      end else begin
         push(dsw_pkg::CMD_MRS, dsw_pkg::BA_MR1, m1 & 14'h3ffe, 17'h1ffff,
            txs);
         push(dsw_pkg::CMD_MRS, dsw_pkg::BA_MR0, m0 | 14'h0100, 17'h1ffff,
            tmrd);
         push(dsw_pkg::CMD_MRS, dsw_pkg::BA_MR2, m2, 17'h1ffff,
            tmrd);
      end
      if (zq)
         push(dsw_pkg::CMD_ZQ, 3'h0, 14'h0, 17'h0, tmod);
      wr(dsw_pkg::OFS_CTRL, {29'h0, zq, off, 1'b1});
      // A second start while busy must not launch another pass
      wr(dsw_pkg::OFS_CTRL, {29'h0, zq, off, 1'b1});
      n = 0;
      do begin
         ahb(1'b0, dsw_pkg::OFS_STAT, 32'h0, r);
         n++;
      end while (r[dsw_pkg::STAT_BUSY] !== 1'b1 && n < 50);
      chk_val("started", 32'h1, {31'h0, r[dsw_pkg::STAT_BUSY]});
      do begin
         ahb(1'b0, dsw_pkg::OFS_STAT, 32'h0, r);
         n++;
      end while (r[dsw_pkg::STAT_BUSY] !== 1'b0 && n < 800);
      chk_val("stat", {29'h0, 1'b1, off, 1'b0}, r);
      n = i_ddr_dev_model.l_c.size() - base;
      chk_val("count", e_w.size(), n);
      for (i = 0; i < e_w.size() && i < n; i++)
         chk_cmd(i);
      chk_val("dll_off", {31'h0, off}, i_ddr_dev_model.dll_dis_q);
      chk_val("pins", 32'h0, i_ddr_dev_model.err_n);
      chk_val("ck_pair", 32'h0, ck_bad);
      rdc("ctrl", dsw_pkg::OFS_CTRL, {29'h0, zq, off, 1'b0});
      rdc("mra", dsw_pkg::OFS_MRA, {2'h0, m1, 2'h0, m0});
      rdc("mrb", dsw_pkg::OFS_MRB, {18'h0, m2});
      $display("switch off=%0d zq=%0d done", off, zq);
   endtask

   initial begin
      repeat (12) @(posedge ref_clk_i);
      rst_b_i <= 1'b1;
      chk_val("hresp", 32'h0, hresp);
      rdc("div", dsw_pkg::OFS_DIV, {24'h0, dsw_pkg::DIV_RST});
      rdc("tima", dsw_pkg::OFS_TIMA, dsw_pkg::TIMA_RST);
      rdc("timb", dsw_pkg::OFS_TIMB, dsw_pkg::TIMB_RST);
      rdc("timc", dsw_pkg::OFS_TIMC, {16'h0, dsw_pkg::TIMC_RST});
      rdc("stat", dsw_pkg::OFS_STAT, 32'h0);
      wr(8'h20, $random(seed));
      rdc("unmapped", 8'h20, 32'h0);
      $display("register reset test done");
      for (k = 0; k < 4; k++) begin
         run_switch(~k[0], k[1]);
         chk_val("relock", (k + 1) / 2, i_ddr_dev_model.rst_n);
      end
      summarize();
   end

   initial begin
      #1000000;
      n_mismatch++;
      summarize();
   end
endmodule // test_ddr_dll_switch_ctrl
